// ### msa_device.sv
// memory select decode, steering ports and shared memory arbiter
// assumes processors hold address and strobes until ready; pins are async
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module msa_device
  import msa_pkg::*;
(
  input  wire logic               core_clk_i,
  input  wire logic               nrst_i,
  input  wire logic               ce_i,
  msa_bus_if.dev                  bus,
  input  wire logic [CFG_W-1:0]   cfg_i,
  input  wire logic               partner_busy_n_i,
  input  wire logic               ext_io_ready_i,
  output logic                    host_prom_ce_n_o,
  output logic                    host_prom_rd_n_o,
  output logic                    host_code_ce_n_o,
  output logic                    host_code_rd_n_o,
  output logic                    host_code_wr_n_o,
  output logic                    host_app_ce_n_o,
  output logic                    host_app_rd_n_o,
  output logic                    host_app_wr_n_o,
  output logic                    host_ram_lo_ce_n_o,
  output logic                    host_ram_hi_ce_n_o,
  output logic                    host_ram_rd_n_o,
  output logic                    host_ram_wr_n_o,
  output logic                    host_pub_sel_n_o,
  output logic [1:0]              sub_prom_ce_n_o,
  output logic [1:0]              sub_flash_ce_n_o,
  output logic [1:0]              sub_flash_wr_n_o,
  output logic [1:0]              sub_ram_lo_ce_n_o,
  output logic [1:0]              sub_ram_hi_ce_n_o,
  output logic [1:0]              sub_rd_n_o,
  output logic [1:0]              sub_wr_n_o,
  output logic                    shm_pub_sel_n_o,
  output logic                    shm_dpm_sel_n_o,
  output logic                    shm_rd_n_o,
  output logic                    shm_wr_n_o,
  output logic                    shm_ube_n_o,
  output logic                    shm_lbe_n_o,
  output logic [AW-1:0]           shm_addr_o,
  output logic [DPM_AW-1:0]       shm_dpm_addr_o,
  output logic [DW-1:0]           shm_wdata_o
);
  typedef struct packed {
    logic [CFG_W-1:0]   cfg_s1;
    logic [CFG_W-1:0]   cfg_s2;
    logic               part_s1;
    logic               part_s2;
    logic               extio_s1;
    logic               extio_s2;
    logic [1:0][DW-1:0] steer;
    logic [DW-1:0]      win_start;
    logic [DW-1:0]      win_end;
    msa_arb_state_t     state;
    logic [1:0]         owner;
    logic [2:0]         cnt;
    logic               pub_sel_n;
    logic               dpm_sel_n;
    logic               rd_n;
    logic               wr_n;
    logic               ube_n;
    logic               lbe_n;
    logic [AW-1:0]      addr;
    logic [DW-1:0]      wdata;
    logic               busy_n;
  } msa_dev_state_t;

  localparam msa_dev_state_t DEV_RST = '{
    steer: {STEER_RST, STEER_RST}, win_start: WIN_START_RST, win_end: WIN_END_RST,
    state: ARB_IDLE, pub_sel_n: 1'b1, dpm_sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
    ube_n: 1'b1, lbe_n: 1'b1, busy_n: 1'b1, part_s1: 1'b1, part_s2: 1'b1,
    default: '0};

  msa_dev_state_t r;
  msa_dev_state_t next_r;

  logic [NPROC-1:0] memrd;
  logic [NPROC-1:0] memwr;
  logic [NPROC-1:0] iocyc;
  logic [NPROC-1:0] shreq;
  logic [NPROC-1:0] to_dpm;
  logic [NPROC-1:0] elig;
  logic [NPROC-1:0] done;

  // per-processor cycle classification
  genvar gp;
  generate
    for (gp = 0; gp < NPROC; gp++) begin : g_cls
      assign memrd[gp] = !bus.rd_n[gp] && bus.io_n[gp];
      assign memwr[gp] = !bus.wr_n[gp] && bus.io_n[gp];
      assign iocyc[gp] = (!bus.rd_n[gp] || !bus.wr_n[gp]) && !bus.io_n[gp];
      // outside every chip select range means a shared request
      assign shreq[gp] = (memrd[gp] || memwr[gp]) && bus.upper_range_select_n[gp]
                         && bus.mid_range_select_n[gp] && bus.local_ram_select_n[gp];
      // inside the programmed window is public memory, else twoport
      assign to_dpm[gp] = !((bus.addr[gp][AW-1:4] >= r.win_start)
                            && (bus.addr[gp][AW-1:4] <= r.win_end));
      // a twoport request waits while the partner holds the twoport bus
      assign elig[gp]  = shreq[gp] && !(to_dpm[gp] && !r.part_s2);
      assign done[gp]  = (r.state == ARB_DONE) && (r.owner == 2'(gp));
    end
  endgenerate

  // next state: synchronisers, io ports and the shared arbiter
  always_comb begin
    logic [1:0] pick;
    pick = 2'h0;
    next_r = r;
    next_r.cfg_s1   = cfg_i;
    next_r.cfg_s2   = r.cfg_s1;
    next_r.part_s1  = partner_busy_n_i;
    next_r.part_s2  = r.part_s1;
    next_r.extio_s1 = ext_io_ready_i;
    next_r.extio_s2 = r.extio_s1;
    // each subordinate writes its own steering port
    for (int i = 1; i < NPROC; i++) begin
      if (iocyc[i] && !bus.wr_n[i] && bus.addr[i] == STEER_PORT) begin
        next_r.steer[i-1] = bus.wdata[i];
      end
    end
    // host sets the public window limits
    if (iocyc[0] && !bus.wr_n[0] && bus.addr[0] == WIN_START_PORT) begin
      next_r.win_start = bus.wdata[0];
    end
    if (iocyc[0] && !bus.wr_n[0] && bus.addr[0] == WIN_END_PORT) begin
      next_r.win_end = bus.wdata[0];
    end
    for (int p = NPROC - 1; p >= 0; p--) begin
      if (elig[p]) begin
        pick = 2'(p);
      end
    end
    case (r.state)
      ARB_IDLE: begin
        if (|elig) begin
          next_r.state     = ARB_ACCESS;
          next_r.owner     = pick;
          next_r.cnt       = SHARED_ACC_CYC - 3'h1;
          next_r.addr      = bus.addr[pick];
          next_r.wdata     = bus.wdata[pick];
          next_r.pub_sel_n = to_dpm[pick];
          next_r.dpm_sel_n = !to_dpm[pick];
          next_r.rd_n      = !memrd[pick];
          next_r.wr_n      = !memwr[pick];
          next_r.ube_n     = bus.upper_byte_enable_n[pick];
          next_r.lbe_n     = bus.lower_byte_enable_n[pick];
          next_r.busy_n    = !to_dpm[pick];
        end
      end
      ARB_ACCESS: begin
        // nobody else is looked at until the count runs out
        if (r.cnt == 3'h0) begin
          next_r.state     = ARB_DONE;
          next_r.pub_sel_n = 1'b1;
          next_r.dpm_sel_n = 1'b1;
          next_r.rd_n      = 1'b1;
          next_r.wr_n      = 1'b1;
          next_r.ube_n     = 1'b1;
          next_r.lbe_n     = 1'b1;
          next_r.busy_n    = 1'b1;
        end else begin
          next_r.cnt = r.cnt - 3'h1;
        end
      end
      ARB_DONE: next_r.state = ARB_IDLE;
      default:  next_r.state = ARB_IDLE;
    endcase
  end

  // state register with clock enable
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      r <= DEV_RST;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // ready: shared waits for its grant, local and internal io answer at once
  always_comb begin
    for (int p = 0; p < NPROC; p++) begin
      bus.ready[p] = done[p]
                     || ((memrd[p] || memwr[p]) && !shreq[p])
                     || (iocyc[p] && p != 0);
    end
    // host io outside its own ports waits for the external ready
    if (iocyc[0] && (bus.addr[0] == WIN_START_PORT || bus.addr[0] == WIN_END_PORT
                     || r.extio_s2)) begin
      bus.ready[0] = 1'b1;
    end
  end
  assign bus.shared_mem_busy_n = r.busy_n;

  // host private memory decode
  logic up;
  logic mid;
  logic low;
  logic app_rd_en;
  logic app_wr_en;
  logic ram_ov;
  logic prom_ce;
  logic app_ce;
  assign up        = !bus.upper_range_select_n[0];
  assign mid       = !bus.mid_range_select_n[0];
  assign low       = !bus.local_ram_select_n[0];
  assign app_rd_en = r.cfg_s2[CFG_APPRD];
  assign app_wr_en = r.cfg_s2[CFG_APPWR];
  assign ram_ov    = r.cfg_s2[CFG_RAMRD] || r.cfg_s2[CFG_RAMWR];
  assign prom_ce   = (up && r.cfg_s2[CFG_BOOT] && r.cfg_s2[CFG_PROMRD])
                     || (mid && !(app_rd_en || app_wr_en));
  assign app_ce    = mid && ((memrd[0] && app_rd_en) || (memwr[0] && app_wr_en));
  assign host_prom_ce_n_o = !prom_ce;
  assign host_prom_rd_n_o = !(memrd[0] && prom_ce);
  assign host_code_ce_n_o = !(up && (!r.cfg_s2[CFG_BOOT] || r.cfg_s2[CFG_CODEWR]));
  assign host_code_rd_n_o = !memrd[0];
  assign host_code_wr_n_o = !(memwr[0] && up && r.cfg_s2[CFG_CODEWR]);
  assign host_app_ce_n_o  = !app_ce;
  assign host_app_rd_n_o  = !(memrd[0] && app_ce && app_rd_en);
  assign host_app_wr_n_o  = !(memwr[0] && app_ce && app_wr_en);
  assign host_ram_lo_ce_n_o = !(!bus.lower_byte_enable_n[0] && (low || (mid && ram_ov)));
  assign host_ram_hi_ce_n_o = !(!bus.upper_byte_enable_n[0] && (low || (mid && ram_ov)));
  assign host_ram_rd_n_o  = !(memrd[0] && (low || (mid && r.cfg_s2[CFG_RAMRD])));
  assign host_ram_wr_n_o  = !(memwr[0] && (low || (mid && r.cfg_s2[CFG_RAMWR])));
  assign host_pub_sel_n_o = !shreq[0];

  // subordinate memory decode steered by each steering port
  generate
    for (gp = 1; gp < NPROC; gp++) begin : g_sub
      logic s_up;
      logic s_ram;
      logic [DW-1:0] st;
      assign st    = r.steer[gp-1];
      assign s_up  = !bus.upper_range_select_n[gp];
      assign s_ram = !bus.local_ram_select_n[gp] && st[STEER_RAM_EN];
      assign sub_prom_ce_n_o[gp-1]   = !(s_up && st[STEER_PROM_RD] && memrd[gp]);
      assign sub_flash_ce_n_o[gp-1]  = !(s_up && !st[STEER_PROM_RD]
                                         && ((memrd[gp] && st[STEER_FLASH_RD])
                                             || (memwr[gp] && st[STEER_FLASH_WR])));
      assign sub_flash_wr_n_o[gp-1]  = !(s_up && memwr[gp] && st[STEER_FLASH_WR]);
      assign sub_ram_lo_ce_n_o[gp-1] = !(s_ram && !bus.lower_byte_enable_n[gp]);
      assign sub_ram_hi_ce_n_o[gp-1] = !(s_ram && !bus.upper_byte_enable_n[gp]);
      assign sub_rd_n_o[gp-1]        = !memrd[gp];
      assign sub_wr_n_o[gp-1]        = !memwr[gp];
    end
  endgenerate

  // shared memory port from the arbiter's registers
  assign shm_pub_sel_n_o = r.pub_sel_n;
  assign shm_dpm_sel_n_o = r.dpm_sel_n;
  assign shm_rd_n_o      = r.rd_n;
  assign shm_wr_n_o      = r.wr_n;
  assign shm_ube_n_o     = r.ube_n;
  assign shm_lbe_n_o     = r.lbe_n;
  assign shm_addr_o      = r.addr;
  assign shm_dpm_addr_o  = r.addr[DPM_AW:1];
  assign shm_wdata_o     = r.wdata;
endmodule : msa_device

// ### msa_pkg.sv
// constants and types shared by the memory select and arbiter ends
// assumes one 40 MHz board clock and a synchronous active-low reset
package msa_pkg;
  localparam int NPROC = 3;                       // host, io scan, comm processors
  localparam int AW    = 20;
  localparam int DW    = 16;
  localparam int CFG_W = 7;
  // processor index on the shared request side
  localparam logic [1:0] HOST_IDX = 2'h0;
  // io ports inside the controller
  localparam logic [AW-1:0] STEER_PORT     = 20'h00080;
  localparam logic [AW-1:0] WIN_START_PORT = 20'h00082;
  localparam logic [AW-1:0] WIN_END_PORT   = 20'h00084;
  // steering control port fields and reset value
  localparam int STEER_PROM_RD  = 0;
  localparam int STEER_FLASH_RD = 1;
  localparam int STEER_FLASH_WR = 2;
  localparam int STEER_RAM_EN   = 3;
  localparam logic [DW-1:0] STEER_RST = 16'h0009;
  // public window limits after reset, 16-byte granules
  localparam logic [DW-1:0] WIN_START_RST = 16'h0000;
  localparam logic [DW-1:0] WIN_END_RST   = 16'hffff;
  // host configuration pin positions
  localparam int CFG_BOOT   = 0;
  localparam int CFG_PROMRD = 1;
  localparam int CFG_CODEWR = 2;
  localparam int CFG_APPRD  = 3;
  localparam int CFG_APPWR  = 4;
  localparam int CFG_RAMRD  = 5;
  localparam int CFG_RAMWR  = 6;
  // shared memory geometry: 32K words of 16 bits
  localparam int DPM_AW = 15;
  // shared memory cycle length
  localparam int CLK_NS        = 25;
  localparam int SHARED_ACC_NS = 100;
  localparam logic [2:0] SHARED_ACC_CYC = 3'((SHARED_ACC_NS + CLK_NS - 1) / CLK_NS);
  // apb register offsets of the processor end
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  // command fields
  localparam int CMD_W        = 10;
  localparam int CMD_GO       = 0;
  localparam int CMD_WRITE    = 1;
  localparam int CMD_KIND_LSB = 2;
  localparam int CMD_PROC_LSB = 4;
  localparam int CMD_UBE      = 6;
  localparam int CMD_LBE      = 7;
  localparam int CMD_RNG_LSB  = 8;
  localparam logic [1:0] KIND_LOCAL = 2'h0;
  localparam logic [1:0] KIND_IO    = 2'h1;
  localparam logic [1:0] KIND_SHARED = 2'h2;
  localparam logic [1:0] RNG_UPPER = 2'h0;
  localparam logic [1:0] RNG_MID   = 2'h1;
  localparam logic [1:0] RNG_LOW   = 2'h2;

  typedef enum logic [1:0] {
    ARB_IDLE   = 2'b00,
    ARB_ACCESS = 2'b01,
    ARB_DONE   = 2'b10
  } msa_arb_state_t;

  typedef enum logic [1:0] {
    PR_IDLE   = 2'b00,
    PR_ADDR   = 2'b01,
    PR_STROBE = 2'b10,
    PR_END    = 2'b11
  } msa_pr_state_t;
endpackage : msa_pkg

// ### msa_bus_if.sv
// processor bus between the three processors and the memory controller
// assumes both ends run on the same board clock
`timescale 1ns/1ps
interface msa_bus_if;
  import msa_pkg::*;
  logic [NPROC-1:0][AW-1:0] addr;
  logic [NPROC-1:0][DW-1:0] wdata;
  logic [NPROC-1:0]         rd_n;
  logic [NPROC-1:0]         wr_n;
  logic [NPROC-1:0]         io_n;
  logic [NPROC-1:0]         upper_range_select_n;
  logic [NPROC-1:0]         mid_range_select_n;
  logic [NPROC-1:0]         local_ram_select_n;
  logic [NPROC-1:0]         upper_byte_enable_n;
  logic [NPROC-1:0]         lower_byte_enable_n;
  logic [NPROC-1:0]         ready;
  logic                     shared_mem_busy_n;

  modport dev (
    input  addr, wdata, rd_n, wr_n, io_n, upper_range_select_n, mid_range_select_n,
    input  local_ram_select_n, upper_byte_enable_n, lower_byte_enable_n,
    output ready, shared_mem_busy_n
  );
  modport procs (
    output addr, wdata, rd_n, wr_n, io_n, upper_range_select_n, mid_range_select_n,
    output local_ram_select_n, upper_byte_enable_n, lower_byte_enable_n,
    input  ready, shared_mem_busy_n
  );
endinterface : msa_bus_if

// ### msa_procs.sv
// processor end: runs one bus cycle on a chosen processor, ordered over apb
// assumes the apb master and the controller share the board clock
`timescale 1ns/1ps
module msa_procs
  import msa_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  msa_bus_if.procs         bus
);
  typedef struct packed {
    msa_pr_state_t    state;
    logic [CMD_W-1:0] cmd;
    logic [AW-1:0]    addr;
    logic [DW-1:0]    wdata;
    logic             done;
  } msa_pr_reg_t;

  localparam msa_pr_reg_t PR_RST = '{state: PR_IDLE, default: '0};

  msa_pr_reg_t r;
  msa_pr_reg_t next_r;
  logic        wr_acc;
  logic        mapped;
  logic [1:0]  kind;
  logic [1:0]  proc;
  logic [1:0]  rng;

  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign mapped = paddr_i == REG_CMD || paddr_i == REG_ADDR || paddr_i == REG_WDATA
                  || paddr_i == REG_STATUS;
  assign kind   = r.cmd[CMD_KIND_LSB +: 2];
  assign proc   = r.cmd[CMD_PROC_LSB +: 2];
  assign rng    = r.cmd[CMD_RNG_LSB +: 2];

  // register writes and the cycle sequencer
  always_comb begin
    next_r = r;
    if (wr_acc && r.state == PR_IDLE) begin
      if (paddr_i == REG_ADDR) begin
        next_r.addr = pwdata_i[AW-1:0];
      end
      if (paddr_i == REG_WDATA) begin
        next_r.wdata = pwdata_i[DW-1:0];
      end
      if (paddr_i == REG_CMD) begin
        next_r.cmd = pwdata_i[CMD_W-1:0];
        if (pwdata_i[CMD_GO]) begin
          next_r.state = PR_ADDR;
          next_r.done  = 1'b0;
        end
      end
    end
    case (r.state)
      PR_IDLE:   next_r.state = next_r.state;
      PR_ADDR:   next_r.state = PR_STROBE; // address settles one cycle first
      PR_STROBE: begin
        if (bus.ready[proc]) begin
          next_r.state = PR_END;
        end
      end
      PR_END: begin
        next_r.state = PR_IDLE;
        next_r.done  = 1'b1;
      end
      default: next_r.state = PR_IDLE;
    endcase
  end

  // state register with clock enable
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      r <= PR_RST;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // drive the chosen processor, all others idle with strobes and selects high, address and data zero
  always_comb begin
    for (int p = 0; p < NPROC; p++) begin
      logic sel;
      logic stb;
      sel = (proc == 2'(p)) && r.state != PR_IDLE && r.state != PR_END;
      stb = sel && r.state == PR_STROBE;
      bus.addr[p]  = sel ? r.addr : '0;
      bus.wdata[p] = sel ? r.wdata : '0;
      bus.rd_n[p]  = !(stb && !r.cmd[CMD_WRITE]);
      bus.wr_n[p]  = !(stb && r.cmd[CMD_WRITE]);
      bus.io_n[p]  = !(sel && kind == KIND_IO);
      bus.upper_range_select_n[p] = !(sel && kind == KIND_LOCAL && rng == RNG_UPPER);
      bus.mid_range_select_n[p]   = !(sel && kind == KIND_LOCAL && rng == RNG_MID);
      bus.local_ram_select_n[p]   = !(sel && kind == KIND_LOCAL && rng == RNG_LOW);
      bus.upper_byte_enable_n[p]  = !(sel && r.cmd[CMD_UBE]);
      bus.lower_byte_enable_n[p]  = !(sel && r.cmd[CMD_LBE]);
    end
  end

  // apb answers at once; unmapped offsets give an error
  always_comb begin
    prdata_o = 32'h00000000;
    case (paddr_i)
      REG_CMD:    prdata_o = {{(32-CMD_W){1'b0}}, r.cmd};
      REG_ADDR:   prdata_o = {{(32-AW){1'b0}}, r.addr};
      REG_WDATA:  prdata_o = {{(32-DW){1'b0}}, r.wdata};
      REG_STATUS: prdata_o = {29'h0, !bus.shared_mem_busy_n, r.done, r.state != PR_IDLE};
      default:    prdata_o = 32'h00000000;
    endcase
  end
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
endmodule : msa_procs

// ### msa_chk.sv
// checker on the processor bus joining the processor end and the controller
// assumes one board clock and a synchronous active-low reset
`timescale 1ns/1ps
module msa_chk
  import msa_pkg::*;
(
  input wire logic                     core_clk_i,
  input wire logic                     nrst_i,
  input wire logic [NPROC-1:0][AW-1:0] addr,
  input wire logic [NPROC-1:0]         rd_n,
  input wire logic [NPROC-1:0]         wr_n,
  input wire logic [NPROC-1:0]         io_n,
  input wire logic [NPROC-1:0]         upper_range_select_n,
  input wire logic [NPROC-1:0]         mid_range_select_n,
  input wire logic [NPROC-1:0]         local_ram_select_n,
  input wire logic [NPROC-1:0]         ready,
  input wire logic                     shared_mem_busy_n
);
  logic [NPROC-1:0] sreq;
  // a memory cycle with no private select is a shared request
  assign sreq = io_n & upper_range_select_n & mid_range_select_n & local_ram_select_n
              & ~(rd_n & wr_n);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // per processor: wait states, bounded answer, address ahead of strobes
  for (genvar i = 0; i < NPROC; i++) begin : g_p
    property p_wait; $rose(sreq[i]) |-> !ready[i] [*5]; endproperty
    a_wait: assert property (p_wait) else $error("ready before shared grant");
    property p_answer; $rose(sreq[i]) |-> ##[5:60] ready[i]; endproperty
    a_answer: assert property (p_answer) else $error("shared ready missing");
    property p_addr_rd; $fell(rd_n[i]) |-> $stable(addr[i]); endproperty
    a_addr_rd: assert property (p_addr_rd) else $error("address moved at read");
    property p_addr_wr; $fell(wr_n[i]) |-> $stable(addr[i]); endproperty
    a_addr_wr: assert property (p_addr_wr) else $error("address moved at write");
    property p_local; !local_ram_select_n[i] && !rd_n[i] |-> ready[i]; endproperty
    a_local: assert property (p_local) else $error("local ram read not ready");
  end
  property p_one; $onehot0(ready & sreq); endproperty
  a_one: assert property (p_one) else $error("two shared grants");
  property p_busy_len;
    $fell(shared_mem_busy_n) |-> !shared_mem_busy_n [*4] ##1 shared_mem_busy_n;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_busy_hold; !shared_mem_busy_n |-> !(|(ready & sreq)); endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("ready during access");
endmodule : msa_chk

// ### tb_memory_select_and_arbiter.sv
// bench joining the processor end to the controller end over the bus
// assumes apb orders the cycles; controller pins driven here
`timescale 1ns/1ps
module tb_memory_select_and_arbiter
  import msa_pkg::*;
;
  logic        core_clk_i = 1'h0;
  logic        nrst_i     = 1'h0;
  logic        psel = 1'h0, pen = 1'h0, pwr = 1'h0, pready, pslverr, perr;
  logic [7:0]  paddr  = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [6:0]  cfg    = 7'h0;
  logic        pbusy_n = 1'h1, ext_rdy = 1'h1;
  logic [12:0] h, hs;          // host decodes, live and captured
  logic [1:0]  sp, sr, sps, srs;
  logic [5:0]  m, ms;          // shared rd, wr, public sel, twoport sel, ube, lbe
  logic [35:0] sw, sws;        // shared address and write data
  logic [14:0] da, das;
  int          num_errors = 0, compares = 0;
  msa_bus_if msa_bus_if_i ();
  always #12.5 core_clk_i = ~core_clk_i;
  // capture what the controller drives while cycles run
  always @(posedge core_clk_i) begin
    if (!(&(msa_bus_if_i.rd_n & msa_bus_if_i.wr_n))) begin
      hs <= h;
      sps <= sp;
      srs <= sr;
    end
    if (!(&m[3:2])) begin
      ms <= m;
      das <= da;
      sws <= sw;
    end
  end
  msa_device msa_device_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(1'h1),
    .bus(msa_bus_if_i), .cfg_i(cfg), .partner_busy_n_i(pbusy_n), .ext_io_ready_i(ext_rdy),
    .host_prom_ce_n_o(h[12]), .host_prom_rd_n_o(h[11]), .host_code_ce_n_o(h[10]),
    .host_code_rd_n_o(h[9]), .host_code_wr_n_o(h[8]), .host_app_ce_n_o(h[7]),
    .host_app_rd_n_o(h[6]), .host_app_wr_n_o(h[5]), .host_ram_lo_ce_n_o(h[4]),
    .host_ram_hi_ce_n_o(h[3]), .host_ram_rd_n_o(h[2]), .host_ram_wr_n_o(h[1]),
    .host_pub_sel_n_o(h[0]), .sub_prom_ce_n_o(sp), .sub_flash_ce_n_o(), .sub_flash_wr_n_o(),
    .sub_ram_lo_ce_n_o(sr), .sub_ram_hi_ce_n_o(), .sub_rd_n_o(), .sub_wr_n_o(),
    .shm_pub_sel_n_o(m[3]), .shm_dpm_sel_n_o(m[2]), .shm_rd_n_o(m[5]), .shm_wr_n_o(m[4]),
    .shm_ube_n_o(m[1]), .shm_lbe_n_o(m[0]), .shm_addr_o(sw[35:16]), .shm_dpm_addr_o(da),
    .shm_wdata_o(sw[15:0]));
  msa_procs msa_procs_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(1'h1),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .bus(msa_bus_if_i));
  msa_chk msa_chk_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr(msa_bus_if_i.addr),
    .rd_n(msa_bus_if_i.rd_n), .wr_n(msa_bus_if_i.wr_n), .io_n(msa_bus_if_i.io_n),
    .upper_range_select_n(msa_bus_if_i.upper_range_select_n),
    .mid_range_select_n(msa_bus_if_i.mid_range_select_n),
    .local_ram_select_n(msa_bus_if_i.local_ram_select_n), .ready(msa_bus_if_i.ready),
    .shared_mem_busy_n(msa_bus_if_i.shared_mem_busy_n));
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    pen <= 1'h1;
    do @(posedge core_clk_i); while (pready !== 1'h1 && ++n < 20);
    if (n == 20) begin
      num_errors++;
      end_of_test();
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge core_clk_i);
  endtask : apb
  // one bus cycle on processor p, waits for done
  task automatic run(input logic [1:0] p, k, r, input logic w, u, l,
                     input logic [19:0] a, input logic [15:0] d);
    int n = 0;
    hs = 'x;
    srs = 'x;
    sps = 'x;
    ms = 'x;
    sws = 'x;
    apb(1'h1, REG_ADDR, {12'h0, a});
    apb(1'h1, REG_WDATA, {16'h0, d});
    apb(1'h1, REG_CMD, {22'h0, r, l, u, p, k, w, 1'h1});
    do apb(1'h0, REG_STATUS, 32'h0); while (rd[1] !== 1'h1 && ++n < 60);
    if (n == 60) begin
      num_errors++;
      end_of_test();
    end
  endtask : run
  function automatic logic [12:0] exp_h(logic [1:0] r, logic sh, w, logic [6:0] c, logic u, l);
    logic up, mi, lo, pr, ap, rm;
    up = !sh && r == RNG_UPPER;
    mi = !sh && r == RNG_MID;
    lo = !sh && r == RNG_LOW;
    pr = up & c[CFG_BOOT] & c[CFG_PROMRD] | mi & !(c[CFG_APPRD] | c[CFG_APPWR]);
    ap = mi & (w ? c[CFG_APPWR] : c[CFG_APPRD]);
    rm = lo | mi & (c[CFG_RAMRD] | c[CFG_RAMWR]);
    return ~{pr, pr & !w, up & (!c[CFG_BOOT] | c[CFG_CODEWR]), !w, up & w & c[CFG_CODEWR],
             ap, ap & !w, ap & w, rm & l, rm & u, !w & (lo | mi & c[CFG_RAMRD]),
             w & (lo | mi & c[CFG_RAMWR]), sh};
  endfunction : exp_h
  task automatic t_reset();
    apb(1'h0, REG_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk(perr, 1'h1);
    $display("reset test done");
  endtask : t_reset
  // host decodes over ranges, directions, pin settings and byte lanes
  task automatic t_decode();
    logic [6:0] c;
    for (int i = 0; i < 3; i++) begin
      c = i == 0 ? 7'h7f : i == 1 ? 7'h00 : 7'h2b;
      cfg <= c;
      repeat (3) @(posedge core_clk_i);
      for (int j = 0; j < 8; j++) begin
        run(2'h0, j[2:1] == 2'h3 ? KIND_SHARED : KIND_LOCAL, j[2:1], j[0], 1'h1, 1'h1,
            20'h01230, 16'ha5c3);
        chk(hs, exp_h(j[2:1], j[2:1] == 2'h3, j[0], c, 1'h1, 1'h1));
      end
    end
    run(2'h0, KIND_LOCAL, RNG_LOW, 1'h0, 1'h1, 1'h0, 20'h00100, 16'h0);
    chk(hs, exp_h(RNG_LOW, 1'h0, 1'h0, c, 1'h1, 1'h0));
    $display("decode test done");
  endtask : t_decode
  // each subordinate owns its steering port
  task automatic t_steer();
    run(2'h1, KIND_IO, 2'h0, 1'h1, 1'h1, 1'h1, STEER_PORT, 16'h0000);
    run(2'h1, KIND_LOCAL, RNG_LOW, 1'h0, 1'h1, 1'h1, 20'h00200, 16'h0);
    chk(srs, 2'h3);
    run(2'h2, KIND_LOCAL, RNG_LOW, 1'h0, 1'h1, 1'h1, 20'h00200, 16'h0);
    chk(srs, 2'h1);
    run(2'h1, KIND_IO, 2'h0, 1'h1, 1'h1, 1'h1, STEER_PORT, 16'h0009);
    run(2'h1, KIND_LOCAL, RNG_UPPER, 1'h0, 1'h1, 1'h1, 20'hf0000, 16'h0);
    chk(sps, 2'h2);
    $display("steering test done");
  endtask : t_steer
  // public window, twoport held by the partner, slow external io
  task automatic t_shared();
    run(2'h0, KIND_IO, 2'h0, 1'h1, 1'h1, 1'h1, WIN_START_PORT, 16'h0010);
    run(2'h0, KIND_IO, 2'h0, 1'h1, 1'h1, 1'h1, WIN_END_PORT, 16'h001f);
    run(2'h1, KIND_SHARED, 2'h0, 1'h0, 1'h1, 1'h1, 20'h00150, 16'h0);
    chk(ms, 6'h14);
    chk(sws, {20'h00150, 16'h0000});
    pbusy_n <= 1'h0;
    fork
      run(2'h2, KIND_SHARED, 2'h0, 1'h1, 1'h0, 1'h1, 20'h0a246, 16'h5a5a);
      begin
        repeat (25) @(posedge core_clk_i);
        chk(m[2], 1'h1);
        chk(msa_bus_if_i.wr_n[2], 1'h0);
        chk(msa_bus_if_i.shared_mem_busy_n, 1'h1);
        pbusy_n <= 1'h1;
      end
    join
    chk(ms, 6'h2a);
    chk(sws, {20'h0a246, 16'h5a5a});
    chk(das, 15'h5123);
    ext_rdy <= 1'h0;
    fork
      run(2'h0, KIND_IO, 2'h0, 1'h0, 1'h1, 1'h1, 20'h00300, 16'h0);
      begin
        repeat (25) @(posedge core_clk_i);
        chk(msa_bus_if_i.ready[0], 1'h0);
        chk(msa_bus_if_i.rd_n[0], 1'h0);
        ext_rdy <= 1'h1;
      end
    join
    $display("shared test done");
  endtask : t_shared
  initial begin
    repeat (3) @(posedge core_clk_i);
    nrst_i <= 1'h1;
    @(posedge core_clk_i);
    t_reset();
    t_decode();
    t_steer();
    t_shared();
    end_of_test();
  end
endmodule : tb_memory_select_and_arbiter
